// ---- design/hpm_pkg.sv ----
// Package for the host port pin function mux: control fields, pin indices and modes.
// Assumes one 10 MHz clock domain and a synchronous active-low reset.
`default_nettype none
package hpm_pkg;

    // Port control bits presented as plain ports.
    localparam int HPM_CTL_W = 8;
    localparam int HPM_CTL_HOST_EN = 0; // Host function selected.
    localparam int HPM_CTL_GPIO_EN = 1; // General-purpose use selected.
    localparam int HPM_CTL_DBL_STROBE = 2; // Double data strobe bus.
    localparam int HPM_CTL_MUXED = 3; // Multiplexed address/data bus.
    localparam int HPM_CTL_DBL_REQ = 4; // Double host request mode.
    localparam int HPM_CTL_REQ_OD = 5; // Request outputs are open-drain.
    localparam int HPM_CTL_REQ_GPIO = 6; // Request pin used as port bit 14.

    // Polarity bits, a set bit means the signal is active high.
    localparam int HPM_POL_W = 4;
    localparam int HPM_POL_STROBE = 0; // Read, write and single strobes.
    localparam int HPM_POL_SELECT = 1; // Chip select.
    localparam int HPM_POL_REQ = 2; // All request outputs.
    localparam int HPM_POL_ACK = 3; // Acknowledge input.

    // Pin indices within the five-pin group and the matching port bit numbers.
    localparam int HPM_PINS = 5;
    localparam int HPM_PIN_RW = 0; // Port bit 11.
    localparam int HPM_PIN_DS = 1; // Port bit 12.
    localparam int HPM_PIN_CS = 2; // Port bit 13.
    localparam int HPM_PIN_REQ = 3; // Port bit 14.
    localparam int HPM_PIN_ACK = 4; // Port bit 15.
    localparam int HPM_PORT_BIT_BASE = 11;

    // Pin group roles.
    typedef enum logic [1:0] {
        HPM_ROLE_OFF = 2'b00,
        HPM_ROLE_HOST = 2'b01,
        HPM_ROLE_GPIO = 2'b10
    } hpm_role_e;

endpackage
`default_nettype wire

// ---- design/hpm_sync.sv ----
// Two flip-flop synchroniser for the pin inputs of the host port group.
// Assumes the pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module hpm_sync
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw pins and their synchronised copy.
    input wire logic [hpm_pkg::HPM_PINS-1:0] pin_in,
    output logic [hpm_pkg::HPM_PINS-1:0] pin_sync
);
    import hpm_pkg::*;

    // State of both stages, the first read only by the second.
    typedef struct packed {
        logic [HPM_PINS-1:0] meta;
        logic [HPM_PINS-1:0] sync;
    } hpm_sync_s;

    hpm_sync_s state_ff; // Registered state.
    hpm_sync_s nxt_state; // Next state.

    // Shift the pins through both stages.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.meta = pin_in;
        nxt_state.sync = state_ff.meta;
    end

    // Register the stages, clearing them at reset.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign pin_sync = state_ff.sync;

endmodule
`default_nettype wire

// ---- design/hpm_pin_mux.sv ----
// Pin function mux for the five upper control pins of the host port.
// Assumes control bits are quasi-static and come from ref_clk logic; pins are asynchronous.
// Functional notes
// - single strobe: rw pin is direction input
// - double strobe: rw pin is read strobe
// - single strobe: ds pin is data strobe
// - double strobe: ds pin is write strobe
// - non-muxed bus: select pin is chip select
// - muxed bus: select pin is address ten
// - single request: combined request, polarity, drive
// - double request: transmit request, polarity, drive
// - single request: acknowledge input, programmable level
// - double request: ack pin becomes receive request
// - gpio use: pins are bits 11, 12, 13, 15
// - bit 14 only when multiplexed and selected
// - stop mode isolates every pin
// - roles derive from port control bits
`timescale 1ns/1ps
`default_nettype none
module hpm_pin_mux
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration from the port control and direction registers.
    input wire logic [hpm_pkg::HPM_CTL_W-1:0] port_control_reg,
    input wire logic [hpm_pkg::HPM_POL_W-1:0] port_polarity,
    input wire logic [hpm_pkg::HPM_PINS-1:0] port_direction_reg,
    input wire logic stop_mode,
    // Host logic request levels, active high.
    input wire logic host_req_int,
    input wire logic host_tx_req_int,
    input wire logic host_rx_req_int,
    // Port data to drive when a bit is an output.
    input wire logic [hpm_pkg::HPM_PINS-1:0] port_data_out,
    // Pad interface: output enable low means driven.
    input wire logic [hpm_pkg::HPM_PINS-1:0] pad_in,
    output logic [hpm_pkg::HPM_PINS-1:0] pad_out,
    output logic [hpm_pkg::HPM_PINS-1:0] pad_oe_n,
    // Decoded host signals, active high.
    output logic host_rw_dir_in,
    output logic host_read_strobe_in,
    output logic host_single_strobe_in,
    output logic host_write_strobe_in,
    output logic host_select_in,
    output logic host_addr_line_ten,
    output logic host_ack_in,
    output logic host_combined_request_out,
    output logic host_tx_request_out,
    output logic host_rx_request_out,
    // General purpose port input bits.
    output logic [hpm_pkg::HPM_PINS-1:0] port_data_in,
    output logic [hpm_pkg::HPM_PINS-1:0] port_bit_valid
);
    import hpm_pkg::*;

    // All registered state of the mux.
    typedef struct packed {
        hpm_role_e role;
        logic rw_dir;
        logic rd_stb;
        logic ds_stb;
        logic wr_stb;
        logic sel;
        logic addr10;
        logic ack;
        logic [HPM_PINS-1:0] gp_in;
        logic [HPM_PINS-1:0] gp_valid;
        logic [HPM_PINS-1:0] out_val;
        logic [HPM_PINS-1:0] oe_n;
    } hpm_mux_s;

    hpm_mux_s state_ff; // Registered state.
    hpm_mux_s nxt_state; // Next state.
    logic [HPM_PINS-1:0] pin_sync; // Synchronised pad levels.
    logic [HPM_CTL_W-1:0] ctl; // Short alias of the control bits.
    logic [HPM_POL_W-1:0] pol; // Short alias of the polarity bits.

    assign ctl = port_control_reg;
    assign pol = port_polarity;

    // Apply a programmable active level; a set polarity bit means active high.
    function automatic logic apply_pol(input logic lvl, input logic act_high);
        apply_pol = act_high ? lvl : ~lvl;
    endfunction

    // The request pin is port bit 14 only on a multiplexed bus with that use chosen.
    function automatic logic req_is_port_bit(input logic [HPM_CTL_W-1:0] c);
        req_is_port_bit = c[HPM_CTL_MUXED] && c[HPM_CTL_REQ_GPIO];
    endfunction

    // Pads pass two flip-flops before any decode reads them.
    hpm_sync u_sync
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(pad_in),
        .pin_sync(pin_sync)
    );

    // Decode the pin roles and fill the next state.
    always_comb
    begin
        nxt_state = '0;
        nxt_state.oe_n = '1;
        // Role follows the control bits; host wins when both are set.
        if (stop_mode)
        begin
            nxt_state.role = HPM_ROLE_OFF;
        end
        else if (ctl[HPM_CTL_HOST_EN])
        begin
            nxt_state.role = HPM_ROLE_HOST;
        end
        else if (ctl[HPM_CTL_GPIO_EN])
        begin
            nxt_state.role = HPM_ROLE_GPIO;
        end
        else
        begin
            nxt_state.role = HPM_ROLE_OFF;
        end
        unique case (nxt_state.role)
            HPM_ROLE_HOST:
            begin
                // Direction and strobes from the two shared strobe pins.
                if (ctl[HPM_CTL_DBL_STROBE])
                begin
                    nxt_state.rd_stb = apply_pol(pin_sync[HPM_PIN_RW], pol[HPM_POL_STROBE]);
                    nxt_state.wr_stb = apply_pol(pin_sync[HPM_PIN_DS], pol[HPM_POL_STROBE]);
                end
                else
                begin
                    nxt_state.rw_dir = pin_sync[HPM_PIN_RW];
                    nxt_state.ds_stb = apply_pol(pin_sync[HPM_PIN_DS], pol[HPM_POL_STROBE]);
                end
                // Select pin is chip select or address line ten.
                if (ctl[HPM_CTL_MUXED])
                begin
                    nxt_state.addr10 = pin_sync[HPM_PIN_CS];
                end
                else
                begin
                    nxt_state.sel = apply_pol(pin_sync[HPM_PIN_CS], pol[HPM_POL_SELECT]);
                end
                // Request pin: a port bit when muxed and so chosen.
                if (req_is_port_bit(ctl))
                begin
                    nxt_state.gp_valid[HPM_PIN_REQ] = 1'b1;
                    nxt_state.gp_in[HPM_PIN_REQ] = pin_sync[HPM_PIN_REQ];
                    nxt_state.out_val[HPM_PIN_REQ] = port_data_out[HPM_PIN_REQ];
                    nxt_state.oe_n[HPM_PIN_REQ] = ~port_direction_reg[HPM_PIN_REQ];
                end
                else if (ctl[HPM_CTL_DBL_REQ])
                begin
                    nxt_state.out_val[HPM_PIN_REQ] = apply_pol(host_tx_req_int, pol[HPM_POL_REQ]);
                    nxt_state.oe_n[HPM_PIN_REQ] = ctl[HPM_CTL_REQ_OD]
                        & (nxt_state.out_val[HPM_PIN_REQ] != 1'b0);
                end
                else
                begin
                    nxt_state.out_val[HPM_PIN_REQ] = apply_pol(host_req_int, pol[HPM_POL_REQ]);
                    nxt_state.oe_n[HPM_PIN_REQ] = ctl[HPM_CTL_REQ_OD]
                        & (nxt_state.out_val[HPM_PIN_REQ] != 1'b0);
                end
                // Acknowledge input or receive request output.
                if (ctl[HPM_CTL_DBL_REQ])
                begin
                    nxt_state.out_val[HPM_PIN_ACK] = apply_pol(host_rx_req_int, pol[HPM_POL_REQ]);
                    nxt_state.oe_n[HPM_PIN_ACK] = ctl[HPM_CTL_REQ_OD]
                        & (nxt_state.out_val[HPM_PIN_ACK] != 1'b0);
                end
                else
                begin
                    nxt_state.ack = apply_pol(pin_sync[HPM_PIN_ACK], pol[HPM_POL_ACK]);
                end
            end
            HPM_ROLE_GPIO:
            begin
                // Pins of bits 11, 12, 13 and 15 are port bits with their own direction.
                nxt_state.gp_valid = '1;
                nxt_state.gp_in = pin_sync;
                nxt_state.out_val = port_data_out;
                nxt_state.oe_n = ~port_direction_reg;
                // The request pin joins as bit 14 only on a multiplexed bus when chosen.
                if (!req_is_port_bit(ctl))
                begin
                    nxt_state.gp_valid[HPM_PIN_REQ] = 1'b0;
                    nxt_state.gp_in[HPM_PIN_REQ] = 1'b0;
                    nxt_state.out_val[HPM_PIN_REQ] = 1'b0;
                    nxt_state.oe_n[HPM_PIN_REQ] = 1'b1;
                end
            end
            HPM_ROLE_OFF:
            begin
                // Disconnected: nothing sampled or driven.
                nxt_state.oe_n = '1;
            end
            default:
            begin
                nxt_state.oe_n = '1;
            end
        endcase
    end

    // Register the decoded state; reset leaves all pins disconnected.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= '0;
            state_ff.oe_n <= '1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Drive pads and decoded inputs from the registered state; request outputs also use live control and request levels.
    assign pad_out = state_ff.out_val;
    assign pad_oe_n = state_ff.oe_n;
    assign host_rw_dir_in = state_ff.rw_dir;
    assign host_read_strobe_in = state_ff.rd_stb;
    assign host_single_strobe_in = state_ff.ds_stb;
    assign host_write_strobe_in = state_ff.wr_stb;
    assign host_select_in = state_ff.sel;
    assign host_addr_line_ten = state_ff.addr10;
    assign host_ack_in = state_ff.ack;
    assign host_combined_request_out = (state_ff.role == HPM_ROLE_HOST) && !ctl[HPM_CTL_DBL_REQ]
        && !req_is_port_bit(ctl) && host_req_int;
    assign host_tx_request_out = (state_ff.role == HPM_ROLE_HOST) && ctl[HPM_CTL_DBL_REQ]
        && !req_is_port_bit(ctl) && host_tx_req_int;
    assign host_rx_request_out = (state_ff.role == HPM_ROLE_HOST) && ctl[HPM_CTL_DBL_REQ] && host_rx_req_int;
    assign port_data_in = state_ff.gp_in;
    assign port_bit_valid = state_ff.gp_valid;

    // Checks of the pin roles.
    AST_STOP_ISOLATES: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_mode |=> (pad_oe_n == '1) && (port_bit_valid == '0))
        else $error("Pin driven or sampled one cycle after stop.");
    AST_RESET_OFF: assert property (@(posedge ref_clk)
        !rst_n |=> (pad_oe_n == '1) && !host_select_in)
        else $error("Pins not disconnected after reset.");
    AST_GPIO_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!stop_mode && !ctl[HPM_CTL_HOST_EN] && ctl[HPM_CTL_GPIO_EN])
        |=> (pad_oe_n[HPM_PIN_CS:HPM_PIN_RW] == ~$past(port_direction_reg[HPM_PIN_CS:HPM_PIN_RW]))
        && (pad_oe_n[HPM_PIN_ACK] == ~$past(port_direction_reg[HPM_PIN_ACK])))
        else $error("Port bit direction does not follow the direction bits.");
    AST_BIT14_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctl[HPM_CTL_HOST_EN] && !ctl[HPM_CTL_MUXED]) |=> !port_bit_valid[HPM_PIN_REQ])
        else $error("Bit 14 active on a non-multiplexed bus.");
    AST_REQ_POL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!stop_mode && ctl[HPM_CTL_HOST_EN] && !ctl[HPM_CTL_REQ_GPIO] && !ctl[HPM_CTL_DBL_REQ] && !ctl[HPM_CTL_REQ_OD])
        |=> (pad_out[HPM_PIN_REQ] == ($past(host_req_int) ~^ $past(pol[HPM_POL_REQ])))
        && !pad_oe_n[HPM_PIN_REQ])
        else $error("Combined request level wrong.");
    AST_RX_OD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!stop_mode && ctl[HPM_CTL_HOST_EN] && ctl[HPM_CTL_DBL_REQ] && ctl[HPM_CTL_REQ_OD])
        |=> (pad_oe_n[HPM_PIN_ACK] == pad_out[HPM_PIN_ACK]))
        else $error("Open-drain receive request drives high.");
    AST_ACK_LAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!stop_mode && ctl[HPM_CTL_HOST_EN] && !ctl[HPM_CTL_DBL_REQ] && pol[HPM_POL_ACK])[*3]
        |-> (host_ack_in == $past(pad_in[HPM_PIN_ACK], 3)))
        else $error("Acknowledge not three cycles behind the pad.");
    AST_SEL_MUX: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctl[HPM_CTL_MUXED]) |=> !host_select_in)
        else $error("Chip select active on a multiplexed bus.");
    AST_RD_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!ctl[HPM_CTL_DBL_STROBE]) |=> !host_read_strobe_in && !host_write_strobe_in)
        else $error("Double strobe outputs active in single strobe mode.");
    AST_DS_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctl[HPM_CTL_DBL_STROBE]) |=> !host_single_strobe_in && !host_rw_dir_in)
        else $error("Single strobe outputs active in double strobe mode.");
    // In general-purpose use without a multiplexed bus the request pin stays cut off.
    AST_GPIO_BIT14: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!stop_mode && !ctl[HPM_CTL_HOST_EN] && ctl[HPM_CTL_GPIO_EN] && !req_is_port_bit(ctl))
        |=> pad_oe_n[HPM_PIN_REQ] && !port_bit_valid[HPM_PIN_REQ])
        else $error("Bit 14 active without a multiplexed bus.");
    // An open-drain transmit request only ever pulls the wire low.
    AST_TX_OD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!stop_mode && ctl[HPM_CTL_HOST_EN] && ctl[HPM_CTL_DBL_REQ] && ctl[HPM_CTL_REQ_OD] && !req_is_port_bit(ctl))
        |=> (pad_oe_n[HPM_PIN_REQ] == pad_out[HPM_PIN_REQ]))
        else $error("Open-drain transmit request drives high.");
    // With neither role chosen the whole group stays quiet.
    AST_OFF_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!ctl[HPM_CTL_HOST_EN] && !ctl[HPM_CTL_GPIO_EN]) |=> (pad_oe_n == '1) && (port_bit_valid == '0))
        else $error("Pins active with no role selected.");
    // The acknowledge input is dead while its pin carries the receive request.
    AST_ACK_DBL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctl[HPM_CTL_HOST_EN] && ctl[HPM_CTL_DBL_REQ]) |=> !host_ack_in)
        else $error("Acknowledge input live in double request mode.");
    // Stop mode must also silence the decoded host inputs.
    AST_STOP_DECODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_mode |=> !host_select_in && !host_ack_in && !host_single_strobe_in && !host_rw_dir_in)
        else $error("Host inputs decoded during stop.");

    // Cover points for the main scenarios.
    COV_HOST: cover property (@(posedge ref_clk) disable iff (!rst_n) state_ff.role == HPM_ROLE_HOST);
    COV_GPIO: cover property (@(posedge ref_clk) disable iff (!rst_n) state_ff.role == HPM_ROLE_GPIO);
    COV_STOP: cover property (@(posedge ref_clk) disable iff (!rst_n) stop_mode ##1 !stop_mode);
    COV_DBLREQ: cover property (@(posedge ref_clk) disable iff (!rst_n) host_rx_request_out);
    COV_BIT14: cover property (@(posedge ref_clk) disable iff (!rst_n) port_bit_valid[HPM_PIN_REQ]);

endmodule
`default_nettype wire

// ---- sim/hpm_host_model.sv ----
// Behavioural host processor on the far side of the five control pins.
// Assumes the device gives a pad value and an active-low output enable.
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model
(
    // Device pad drive.
    input wire logic [hpm_pkg::HPM_PINS-1:0] pad_out,
    input wire logic [hpm_pkg::HPM_PINS-1:0] pad_oe_n,
    // Host drive values and enables.
    input wire logic [hpm_pkg::HPM_PINS-1:0] host_drv,
    input wire logic [hpm_pkg::HPM_PINS-1:0] host_en,
    // Resolved wire levels seen by both parties.
    output logic [hpm_pkg::HPM_PINS-1:0] pin_level
);
    import hpm_pkg::*;
    // Each wire has a pull-up, so a wire nobody drives reads high.
    always_comb
    begin
        for (int i = 0; i < HPM_PINS; i++)
        begin
            if (!pad_oe_n[i])
                pin_level[i] = pad_out[i];
            else if (host_en[i])
                pin_level[i] = host_drv[i];
            else
                pin_level[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- sim/hpm_pin_mux_tb.sv ----
// Self-checking bench for the host port pin function mux.
// Assumes hpm_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module hpm_pin_mux_tb;
    import hpm_pkg::*;
    // Stimulus, all changed at the falling clock edge.
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] ctl = 8'h01;
    logic [3:0] pol = 4'hf;
    logic [4:0] dir = 5'h00;
    logic stop = 1'b0;
    logic [2:0] req = 3'h1;
    logic [4:0] pdo = 5'h1b;
    logic [4:0] hdrv = 5'h1f;
    logic [4:0] hen = 5'h17;
    // Design outputs and resolved wires.
    logic [4:0] pad_out, pad_oe_n, pin, pdi, pbv;
    logic rw, rds, sds, wds, sel, a10, ack, creq, treq, rreq;
    logic [7:0] cl[4] = '{8'h01, 8'h21, 8'h1d, 8'h3d};
    logic [4:0] vl[2] = '{5'h15, 5'h0a};
    int fail_count = 0;
    int total_checks = 0;

    // Clock of 100 ns period.
    always #50 ref_clk = ~ref_clk;

    hpm_pin_mux DUT (.ref_clk(ref_clk), .rst_n(rst_n), .port_control_reg(ctl), .port_polarity(pol),
        .port_direction_reg(dir), .stop_mode(stop), .host_req_int(req[0]), .host_tx_req_int(req[1]),
        .host_rx_req_int(req[2]), .port_data_out(pdo), .pad_in(pin), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .host_rw_dir_in(rw), .host_read_strobe_in(rds),
        .host_single_strobe_in(sds), .host_write_strobe_in(wds), .host_select_in(sel),
        .host_addr_line_ten(a10), .host_ack_in(ack), .host_combined_request_out(creq),
        .host_tx_request_out(treq), .host_rx_request_out(rreq), .port_data_in(pdi),
        .port_bit_valid(pbv));

    hpm_host_model host (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .host_drv(hdrv), .host_en(hen),
        .pin_level(pin));

    // Widens one bit without letting an inversion spill into upper bits.
    function automatic logic [4:0] b(input logic x);
        return {4'h0, x};
    endfunction

    // Compares a value seen with the value expected.
    task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Sets configuration, host pin drive and requests, then waits past the sync delay.
    task automatic apply(input logic [7:0] c, input logic [3:0] p, input logic [4:0] d, input logic s,
        input logic [4:0] v, input logic [4:0] e, input logic [2:0] r);
        ctl = c;
        pol = p;
        dir = d;
        stop = s;
        hdrv = v;
        hen = e;
        req = r;
        repeat (4) @(negedge ref_clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cuts a hang short; the tests need about 11 us.
    initial
    begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    // Main test sequence.
    initial
    begin
        logic [7:0] c;
        logic [3:0] p;
        logic [4:0] v;
        logic [4:0] d;
        logic [4:0] m;
        logic dr, od, v3, v4;
        // Host mode is asked for while reset holds; the pins must stay cut off.
        repeat (11) @(negedge ref_clk);
        check("reset_oe_n", pad_oe_n, 5'h1f);
        check("reset_select", b(sel), 5'h00);
        check("reset_req", b(creq), 5'h00);
        @(negedge ref_clk);
        rst_n = 1'b1;
        apply(8'h00, 4'hf, 5'h1f, 1'b0, 5'h1f, 5'h17, 3'h7);
        check("idle_oe_n", pad_oe_n, 5'h1f);
        $display("test reset done");
        // Four host configurations with both polarities and two pin patterns.
        foreach (cl[i])
            for (int j = 0; j < 2; j++)
                foreach (vl[k])
                begin
                    c = cl[i];
                    p = j ? 4'hf : 4'h0;
                    v = vl[k];
                    dr = c[4];
                    od = c[5];
                    apply(c, p, 5'h00, 1'b0, v, dr ? 5'h07 : 5'h17, v[2:0]);
                    v3 = (dr ? v[1] : v[0]) ^ ~p[2];
                    v4 = v[2] ^ ~p[2];
                    check("rw_dir", b(rw), b(~c[2] & v[0]));
                    check("read_strobe", b(rds), b(c[2] & (v[0] ^ ~p[0])));
                    check("single_strobe", b(sds), b(~c[2] & (v[1] ^ ~p[0])));
                    check("write_strobe", b(wds), b(c[2] & (v[1] ^ ~p[0])));
                    check("select", b(sel), b(~c[3] & (v[2] ^ ~p[1])));
                    check("addr_ten", b(a10), b(c[3] & v[2]));
                    check("ack", b(ack), b(~dr & (v[4] ^ ~p[3])));
                    check("comb_req", b(creq), b(~dr & v[0]));
                    check("tx_req", b(treq), b(dr & v[1]));
                    check("rx_req", b(rreq), b(dr & v[2]));
                    check("req_pin", b(pin[3]), b(v3));
                    check("rx_pin", b(pin[4]), b(dr ? v4 : v[4]));
                    check("host_oe_n", pad_oe_n, {dr ? od & v4 : 1'b1, od & v3, 3'b111});
                end
        $display("test host_modes done");
        // General-purpose use with mixed directions; bit 14 only on a multiplexed bus.
        for (int j = 0; j < 2; j++)
        begin
            d = j ? 5'h13 : 5'h0c;
            m = j ? 5'h1f : 5'h17;
            apply(j ? 8'h4a : 8'h02, 4'h0, d, 1'b0, 5'h0e, ~d, 3'h7);
            check("gpio_oe_n", pad_oe_n, ~d | ~m);
            check("gpio_pin", pin, (d & pdo) | (~d & 5'h0e));
            check("gpio_in", pdi, ((d & pdo) | (~d & 5'h0e)) & m);
            check("gpio_valid", pbv, m);
            check("gpio_select", b(sel), 5'h00);
        end
        $display("test gpio done");
        // Request pin as port bit 14 only on a multiplexed bus.
        apply(8'h49, 4'hf, 5'h08, 1'b0, 5'h00, 5'h17, 3'h0);
        check("bit14_valid", pbv, 5'h08);
        check("bit14_oe_n", pad_oe_n, 5'h17);
        check("bit14_pin", b(pin[3]), 5'h01);
        apply(8'h49, 4'hf, 5'h00, 1'b0, 5'h00, 5'h1f, 3'h1);
        check("bit14_in", b(pdi[3]), 5'h00);
        check("bit14_req", b(creq), 5'h00);
        apply(8'h41, 4'hf, 5'h08, 1'b0, 5'h00, 5'h17, 3'h0);
        check("nomux_valid", pbv, 5'h00);
        check("nomux_pin", b(pin[3]), 5'h00);
        $display("test bit14 done");
        // Stop mode isolates the pins in both roles.
        apply(8'h01, 4'hf, 5'h00, 1'b1, 5'h1f, 5'h17, 3'h1);
        check("stop_oe_n", pad_oe_n, 5'h1f);
        check("stop_select", b(sel), 5'h00);
        check("stop_ack", b(ack), 5'h00);
        apply(8'h02, 4'hf, 5'h1f, 1'b1, 5'h00, 5'h00, 3'h0);
        check("stop_gpio_oe_n", pad_oe_n, 5'h1f);
        apply(8'h02, 4'hf, 5'h1f, 1'b0, 5'h00, 5'h00, 3'h0);
        check("wake_oe_n", pad_oe_n, 5'h08);
        $display("test stop done");
        report_and_stop();
    end
endmodule
`default_nettype wire
